// ### hw/i2c_flag_pkg.sv
// Constants shared by the start generator and the bus event detector.
// Assumes a single 125 MHz clock and an asynchronous active-low reset.
//
// Functional notes
// - Guarantee bus free time before own start
// - Hold start request until bus released
// - NACK then falling SCL clears tx flag
// - Start on bus clears stop/nack flags, sets start flag
// - Auto clear right after request is hazardous
// - Hazard limited to three flag sources
`default_nettype none

package i2c_flag_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  // Bus free time, stop to next start
  localparam int TBUF_STD_NS = 4700;
  localparam int TBUF_FAST_NS = 1300;
  // Start hold time, SDA low to SCL low
  localparam int THD_STD_NS = 4000;
  localparam int THD_FAST_NS = 600;
  localparam int CNT_W = 10;
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] TBUF_STD_CYC = CNT_W'((TBUF_STD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] TBUF_FAST_CYC = CNT_W'((TBUF_FAST_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] THD_STD_CYC = CNT_W'((THD_STD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] THD_FAST_CYC = CNT_W'((THD_FAST_NS * CLK_MHZ + 999) / 1000);
  // Critical window after an interrupt request, in clock cycles
  localparam logic [2:0] HAZARD_CYC = 3'h6;

  // ----------------------------------------------------------------
  // Flags and vectors
  // ----------------------------------------------------------------
  localparam int FLAG_TX = 0;
  localparam int FLAG_STOP = 1;
  localparam int FLAG_START = 2;
  localparam int FLAG_NACK = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [2:0] VEC_NONE = 3'h0;
  localparam logic [2:0] VEC_NACK = 3'h1;
  localparam logic [2:0] VEC_START = 3'h2;
  localparam logic [2:0] VEC_STOP = 3'h3;
  localparam logic [2:0] VEC_TX = 3'h4;

  typedef enum logic [1:0] {S_IDLE, S_WAIT_FREE, S_SDA_LOW, S_SCL_LOW} gen_state_t;
endpackage

`default_nettype wire

// ### hw/bus_events_if.sv
// Bus events passed from the pin detector to the flag core.
// Assumes both ends run on the same clock.
`default_nettype none

interface bus_events_if;
  logic start_pulse; // Start condition seen, one cycle
  logic stop_pulse;  // Stop condition seen, one cycle
  logic scl_fall;    // SCL falling edge, one cycle
  logic scl_level;   // Synchronised SCL
  logic sda_level;   // Synchronised SDA
  modport det (output start_pulse, stop_pulse, scl_fall, scl_level, sda_level);
  modport core (input start_pulse, stop_pulse, scl_fall, scl_level, sda_level);
endinterface

`default_nettype wire

// ### hw/bus_event_detect.sv
// Synchronises SCL and SDA and detects start, stop and SCL falls.
// Assumes the pins are asynchronous to clk.
`default_nettype none

module bus_event_detect
  import i2c_flag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Events
  bus_events_if.det ev
);
  logic scl_s1, scl_s2, scl_p; // Sync stages and previous value
  logic sda_s1, sda_s2, sda_p;

  // ----------------------------------------------------------------
  // Two-stage synchronisers; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Idle bus reads high
      {scl_s1, scl_s2, scl_p} <= 3'h7;
      {sda_s1, sda_s2, sda_p} <= 3'h7;
    end else begin
      {scl_s1, scl_s2, scl_p} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_p} <= {sda_in, sda_s1, sda_s2};
    end
  end

  // ----------------------------------------------------------------
  // Edge decode
  // ----------------------------------------------------------------
  // SDA falling while SCL stays high is a start
  assign ev.start_pulse = scl_s2 & scl_p & sda_p & ~sda_s2;
  assign ev.stop_pulse = scl_s2 & scl_p & ~sda_p & sda_s2;
  assign ev.scl_fall = scl_p & ~scl_s2;
  assign ev.scl_level = scl_s2;
  assign ev.sda_level = sda_s2;

  // Start needs SCL high in two samples
  det_start_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ev.start_pulse |-> $past(scl_s2) && scl_s2 && $past(sda_s2) && !sda_s2)
    else $error("start pulse without SDA fall under high SCL");
endmodule // bus_event_detect

`default_nettype wire

// ### hw/i2c_start_and_flag_clearing.sv
// Start generator with bus free guard, and interrupt flags that the
// bus clears on its own, with a vector captured at acceptance.
// Assumes open-drain pins and flag set pulses from same-clock logic.
`default_nettype none

module i2c_start_and_flag_clearing
  import i2c_flag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus pins, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Start control
  input wire logic start_request_bit,
  input wire logic fast_mode,
  output logic start_sent,
  output logic bus_busy_flag,
  // Flag set sources
  input wire logic tx_empty_set,
  input wire logic nack_set,
  // Software flag clears
  input wire logic clear_tx,
  input wire logic clear_stop,
  input wire logic clear_start,
  input wire logic clear_nack,
  // Flags
  output logic tx_buffer_empty_flag,
  output logic stop_seen_flag,
  output logic start_seen_flag,
  output logic nack_seen_flag,
  // Interrupt request and acceptance
  input wire logic [3:0] irq_enable,
  output logic irq_request,
  input wire logic irq_accept,
  output logic [2:0] irq_vector
);
  bus_events_if ev ();

  // Pin event detector
  bus_event_detect u_det (
    .clk(clk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // Start generator
  // ----------------------------------------------------------------
  gen_state_t state, next_state;
  logic [CNT_W-1:0] idle_cnt; // Cycles the bus has been free
  logic [CNT_W-1:0] hold_cnt; // Cycles SDA has been held low
  logic [CNT_W-1:0] tbuf_need; // Free time for this mode
  logic [CNT_W-1:0] thd_need;
  logic bus_idle;
  logic free_ok;
  logic hold_ok;
  logic sda_pull;
  logic scl_pull;

  assign tbuf_need = fast_mode ? TBUF_FAST_CYC : TBUF_STD_CYC;
  assign thd_need = fast_mode ? THD_FAST_CYC : THD_STD_CYC;
  assign bus_idle = ~bus_busy_flag & ev.scl_level & ev.sda_level;
  assign free_ok = idle_cnt >= tbuf_need;
  assign hold_ok = hold_cnt >= thd_need;
  assign sda_pull = (state == S_SDA_LOW) || (state == S_SCL_LOW);
  assign scl_pull = state == S_SCL_LOW;
  // Open drain: drive low only, enable is active low
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_n = ~sda_pull;
  assign scl_oe_n = ~scl_pull;

  // Next state of the start generator
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start_request_bit) begin
          next_state = S_WAIT_FREE;
        end
      end
      S_WAIT_FREE: begin
        if (!start_request_bit) begin
          next_state = S_IDLE;
        end else if (bus_idle && free_ok) begin
          next_state = S_SDA_LOW;
        end
      end
      S_SDA_LOW: begin
        if (hold_ok) begin
          next_state = S_SCL_LOW;
        end
      end
      // Bus stays claimed until software drops the request
      S_SCL_LOW: begin
        if (!start_request_bit) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // State register and start pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      start_sent <= 1'b0;
    end else begin
      state <= next_state;
      start_sent <= (state == S_SDA_LOW) && (next_state == S_SCL_LOW);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt <= '0;
    end else if (!bus_idle) begin
      // Any activity restarts the count
      idle_cnt <= '0;
    end else if (!free_ok) begin
      idle_cnt <= idle_cnt + CNT_W'(1);
    end
  end

  // Start hold count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hold_cnt <= '0;
    end else if (state != S_SDA_LOW) begin
      hold_cnt <= '0;
    end else if (!hold_ok) begin
      hold_cnt <= hold_cnt + CNT_W'(1);
    end
  end

  // Busy from any start to the next stop, ours included
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_busy_flag <= 1'b0;
    end else if (ev.start_pulse) begin
      bus_busy_flag <= 1'b1;
    end else if (ev.stop_pulse) begin
      bus_busy_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  logic nack_armed; // NACK seen, waiting for next SCL fall
  logic auto_clr_tx;
  logic next_tx, next_stop, next_start, next_nack;

  assign auto_clr_tx = nack_armed & ev.scl_fall;
  // Set always beats any clear in the same cycle
  assign next_tx = tx_empty_set | (tx_buffer_empty_flag & ~clear_tx & ~auto_clr_tx);
  assign next_stop = ev.stop_pulse | (stop_seen_flag & ~clear_stop & ~ev.start_pulse);
  assign next_start = ev.start_pulse | (start_seen_flag & ~clear_start);
  assign next_nack = nack_set | (nack_seen_flag & ~clear_nack & ~ev.start_pulse);

  // Flag registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {nack_seen_flag, start_seen_flag, stop_seen_flag, tx_buffer_empty_flag} <= FLAGS_RESET;
      nack_armed <= 1'b0;
    end else begin
      {nack_seen_flag, start_seen_flag, stop_seen_flag, tx_buffer_empty_flag} <=
        {next_nack, next_start, next_stop, next_tx};
      nack_armed <= nack_set | (nack_armed & ~ev.scl_fall);
    end
  end

  // ----------------------------------------------------------------
  // Request and vector capture
  // ----------------------------------------------------------------
  logic [3:0] live; // Enabled, pending flags
  logic [2:0] live_vec;
  logic [2:0] snap_vec; // Source seen when the request rose
  logic [2:0] win_cnt; // Cycles left in the critical window
  logic req_q;
  logic [2:0] next_vec;

  assign live = irq_enable &
    {nack_seen_flag, start_seen_flag, stop_seen_flag, tx_buffer_empty_flag};
  assign irq_request = |live;
  assign live_vec = live[FLAG_NACK] ? VEC_NACK :
                    live[FLAG_START] ? VEC_START :
                    live[FLAG_STOP] ? VEC_STOP :
                    live[FLAG_TX] ? VEC_TX : VEC_NONE;
  assign next_vec = (live_vec != VEC_NONE) ? live_vec :
                    (win_cnt != 3'h0) ? snap_vec : VEC_NONE;

  // Snapshot keeps a source that an auto clear wipes just before acceptance
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_q <= 1'b0;
      snap_vec <= VEC_NONE;
      win_cnt <= 3'h0;
    end else begin
      req_q <= irq_request;
      if (irq_request && !req_q) begin
        snap_vec <= live_vec;
        win_cnt <= HAZARD_CYC;
      end else if (win_cnt != 3'h0) begin
        win_cnt <= win_cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_vector <= VEC_NONE;
    end else if (irq_accept) begin
      irq_vector <= next_vec;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  tbuf_guard_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(sda_pull) |-> $past(idle_cnt) >= $past(tbuf_need))
    else $error("own start issued before bus free time");
  busy_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(sda_pull) |-> !$past(bus_busy_flag) && $past(start_request_bit))
    else $error("start driven on a busy bus or without request");
  busy_track_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ev.stop_pulse |=> !bus_busy_flag ##0 !$rose(sda_pull))
    else $error("busy flag not released by stop");
  tx_autoclr_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    nack_armed && ev.scl_fall && !tx_empty_set |=> !tx_buffer_empty_flag)
    else $error("tx flag survived SCL fall after NACK");
  start_clear_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    ev.start_pulse && !nack_set |=> !stop_seen_flag && !nack_seen_flag && start_seen_flag)
    else $error("start did not clear stop and nack flags");
  set_wins_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    tx_empty_set && (clear_tx || auto_clr_tx) |=> tx_buffer_empty_flag)
    else $error("clear beat a simultaneous set");
  window_vec_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    irq_accept && (win_cnt != 3'h0) |=> irq_vector != VEC_NONE)
    else $error("vector lost inside critical window");
  vector_hold_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    !irq_accept |=> $stable(irq_vector))
    else $error("vector changed without acceptance");
endmodule // i2c_start_and_flag_clearing

`default_nettype wire

// ### testbench/i2c_bus_peer.sv
// Behavioural second master sharing SCL and SDA with the block.
// Assumes pull-ups on both lines; a released line reads high.
`default_nettype none

module i2c_bus_peer (
  // Clock
  input wire logic clk,
  // Open-drain drives, 1 = released
  output var logic scl_rel,
  output var logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Line sequences
  // ----------------------------------------------------------------
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
  end

  // Lines move only on falling clock edges, well clear of sampling
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // SDA falls while SCL high, then SCL is taken low
  task automatic start_cond();
    sda_rel = 1'b0;
    hold(10);
    scl_rel = 1'b0;
    hold(10);
  endtask

  // SDA low, SCL released, then SDA rises while SCL high
  task automatic stop_cond();
    sda_rel = 1'b0;
    hold(10);
    scl_rel = 1'b1;
    hold(10);
    sda_rel = 1'b1;
    hold(10);
  endtask

  // One SCL clock pulse ending low, giving one falling edge
  task automatic scl_pulse();
    scl_rel = 1'b1;
    hold(10);
    scl_rel = 1'b0;
    hold(10);
  endtask

  // Both lines set at once, then held for n falling clock edges
  task automatic lines(input logic scl_v, input logic sda_v, input int n);
    scl_rel = scl_v;
    sda_rel = sda_v;
    hold(n);
  endtask
endmodule // i2c_bus_peer

`default_nettype wire

// ### testbench/i2c_start_and_flag_clearing_tb_top.sv
// Self-checking bench for start generation and automatic flag clears.
// Assumes the design package and the bus peer model are compiled first.
`default_nettype none

module i2c_start_and_flag_clearing_tb_top;
  import i2c_flag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, start_sent, bus_busy_flag;
  logic start_request_bit = 1'b0, fast_mode = 1'b1;
  logic tx_empty_set = 1'b0, nack_set = 1'b0, clear_start = 1'b0;
  logic clear_tx = 1'b0, clear_stop = 1'b0, clear_nack = 1'b0;
  logic tx_buffer_empty_flag, stop_seen_flag, start_seen_flag, nack_seen_flag;
  logic [3:0] irq_enable = 4'h0;
  logic irq_request, irq_accept = 1'b0;
  logic [2:0] irq_vector;
  logic scl_rel, sda_rel;
  int n_fail = 0, compares = 0, n, h;
  // Wired-AND of all parties; released means pulled up
  wire scl = (scl_oe_n | scl_out) & scl_rel;
  wire sda = (sda_oe_n | sda_out) & sda_rel;

  always #4 clk = ~clk;

  i2c_bus_peer i_i2c_bus_peer (.clk(clk), .scl_rel(scl_rel), .sda_rel(sda_rel));

  i2c_start_and_flag_clearing i_i2c_start_and_flag_clearing (
    .clk(clk), .reset_n(reset_n), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .start_request_bit(start_request_bit), .fast_mode(fast_mode), .start_sent(start_sent),
    .bus_busy_flag(bus_busy_flag), .tx_empty_set(tx_empty_set), .nack_set(nack_set),
    .clear_tx(clear_tx), .clear_stop(clear_stop), .clear_start(clear_start),
    .clear_nack(clear_nack),
    .tx_buffer_empty_flag(tx_buffer_empty_flag), .stop_seen_flag(stop_seen_flag),
    .start_seen_flag(start_seen_flag), .nack_seen_flag(nack_seen_flag),
    .irq_enable(irq_enable), .irq_request(irq_request), .irq_accept(irq_accept),
    .irq_vector(irq_vector));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Case inequality so an unknown never counts as a match
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Single-cycle pulse on a design input
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    #200000;
    n_fail++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    chk("oe_n idle", {scl_oe_n, sda_oe_n, bus_busy_flag, irq_vector}, 32'h30);
    // Peer start marks bus busy and sets start flag
    i_i2c_bus_peer.start_cond();
    chk("busy", {bus_busy_flag, start_seen_flag}, 32'h3);
    pulse(tx_empty_set);
    pulse(nack_set);
    i_i2c_bus_peer.hold(2);
    chk("tx set", {tx_buffer_empty_flag, nack_seen_flag}, 32'h3);
    i_i2c_bus_peer.scl_pulse();
    chk("tx auto clear", tx_buffer_empty_flag, 1'b0);
    i_i2c_bus_peer.stop_cond();
    chk("stop seen", {stop_seen_flag, bus_busy_flag}, 32'h2);
    i_i2c_bus_peer.start_cond();
    chk("start clears", {stop_seen_flag, nack_seen_flag, start_seen_flag}, 32'h1);
    start_request_bit = 1'b1;
    i_i2c_bus_peer.hold(700);
    chk("held while busy", sda_oe_n, 1'b1);
    i_i2c_bus_peer.stop_cond();
    for (n = 0; n < 1000 && sda_oe_n !== 1'b0; n++) @(negedge clk);
    chk("tbuf", (n >= TBUF_FAST_CYC - 14) && (n <= TBUF_FAST_CYC), 1'b1);
    for (h = 0; h < 1000 && start_sent !== 1'b1; h++) @(negedge clk);
    chk("hold time", (h >= THD_FAST_CYC - 2) && (h <= THD_FAST_CYC + 2), 1'b1);
    chk("scl low", {scl_oe_n, sda_oe_n}, 32'h0);
    start_request_bit = 1'b0;
    @(negedge clk);
    chk("release", {scl_oe_n, sda_oe_n}, 32'h3);
    // auto clear inside the window keeps the captured vector
    pulse(clear_start);
    irq_enable = 4'h2;
    i_i2c_bus_peer.start_cond();
    i_i2c_bus_peer.lines(1'b0, 1'b0, 10);
    i_i2c_bus_peer.lines(1'b1, 1'b0, 10);
    i_i2c_bus_peer.lines(1'b1, 1'b1, 0);
    for (n = 0; n < 20 && stop_seen_flag !== 1'b1; n++) @(negedge clk);
    chk("stop irq", irq_request, 1'b1);
    i_i2c_bus_peer.lines(1'b1, 1'b0, 4);
    chk("stop cleared", stop_seen_flag, 1'b0);
    pulse(irq_accept);
    chk("vector", irq_vector, VEC_STOP);
    irq_enable = 4'h0;
    pulse(nack_set);
    chk("poll nack", {nack_seen_flag, irq_request}, 32'h2);
    // software clears of polled flags; a set in the same cycle wins
    nack_set = 1'b1;
    clear_nack = 1'b1;
    @(negedge clk);
    nack_set = 1'b0;
    clear_nack = 1'b0;
    chk("set beats clear", nack_seen_flag, 1'b1);
    pulse(clear_nack);
    chk("nack clear", nack_seen_flag, 1'b0);
    pulse(clear_start);
    chk("start clear", start_seen_flag, 1'b0);
    pulse(tx_empty_set);
    chk("tx set again", tx_buffer_empty_flag, 1'b1);
    pulse(clear_tx);
    chk("tx clear", tx_buffer_empty_flag, 1'b0);
    // stop irq accepted, auto clear comes long after six cycles
    fast_mode = 1'b0;
    irq_enable = 4'h2;
    i_i2c_bus_peer.lines(1'b1, 1'b1, 10);
    pulse(irq_accept);
    repeat (8) @(negedge clk);
    chk("stop vector", irq_vector, VEC_STOP);
    // software sees a free bus before asking for a start
    for (n = 0; n < 10 && bus_busy_flag !== 1'b0; n++) @(negedge clk);
    start_request_bit = 1'b1;
    for (n = 0; n < 1000 && sda_oe_n !== 1'b0; n++) @(negedge clk);
    chk("tbuf std", (n >= TBUF_STD_CYC - 30) && (n <= TBUF_STD_CYC), 1'b1);
    for (h = 0; h < 1000 && start_sent !== 1'b1; h++) @(negedge clk);
    chk("hold std", (h >= THD_STD_CYC - 2) && (h <= THD_STD_CYC + 2), 1'b1);
    chk("own start clears stop", stop_seen_flag, 1'b0);
    chk("vector kept", irq_vector, VEC_STOP);
    start_request_bit = 1'b0;
    @(negedge clk);
    // Peer frame to raise the stop flag for a software clear
    i_i2c_bus_peer.lines(1'b1, 1'b0, 10);
    i_i2c_bus_peer.lines(1'b1, 1'b1, 10);
    chk("stop again", {stop_seen_flag, bus_busy_flag}, 32'h2);
    pulse(clear_stop);
    chk("stop clear", stop_seen_flag, 1'b0);
    end_sim();
  end
endmodule // i2c_start_and_flag_clearing_tb_top

`default_nettype wire
